// *** hdl/tcs_seq.sv ***
// control and status sequencer of the pluggable transceiver
`default_nettype none
`include "tcs_map.svh"
module tcs_seq
  import tcs_pkg::*;
#(
  parameter logic [31:0] START_CYC = `TCS_CYC_MS(`TCS_T_START_MS),
  parameter logic [31:0] START_COOL_CYC = `TCS_CYC_S(`TCS_T_START_COOL_S),
  // related bounds scale from one count, so a short run needs few overrides
  parameter logic [31:0] MGMT_CYC  =
    START_CYC * `TCS_T_2W_MS / `TCS_T_START_MS,
  parameter logic [31:0] PL2_CYC   =
    START_CYC * `TCS_T_PL2_MS / `TCS_T_START_MS,
  parameter logic [31:0] PDN_CYC   =
    START_CYC * `TCS_T_PDN_MS / `TCS_T_START_MS,
  parameter logic [31:0] ON_CYC    = `TCS_CYC_MS(`TCS_T_ON_MS),
  parameter logic [31:0] FLT_CYC   = `TCS_CYC_MS(`TCS_T_FLT_MS),
  parameter logic [31:0] FLT_COOL_CYC =
    FLT_CYC * `TCS_T_FLT_COOL_MS / `TCS_T_FLT_MS,
  parameter logic [31:0] RS_FC_CYC = `TCS_CYC_US(`TCS_T_RS_FC_US),
  parameter logic [31:0] RS_CYC    =
    RS_FC_CYC * (`TCS_T_RS_MS * 1000) / `TCS_T_RS_FC_US
) (
  input  wire logic        core_clk,        // 20 MHz clock
  input  wire logic        resetn,          // sync reset, active low
  input  wire tcs_pins_t   pins_in,         // asynchronous pin inputs
  input  wire logic        cooled,          // variant strap
  input  wire logic        fc_mode,         // fibre channel rate timing
  input  wire logic        hpl_write,       // stop of level write, pulse
  input  wire logic        hpl_value,       // level written: 1 = high
  output tcs_status_t      status           // registered outputs
);
  localparam logic [31:0] RESET_CYC = `TCS_CYC_RESET;
  localparam logic [31:0] LOS_CYC   = `TCS_CYC_LOS;

  tcs_pins_t   sync1_reg;
  tcs_pins_t   sync2_reg;
  tcs_pins_t   prev_reg;
  tcs_state_t  state_reg;
  tcs_state_t  state_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  logic [31:0] mgmt_reg;
  logic [31:0] hold_reg;
  logic [31:0] flt_reg;
  logic [31:0] rs_reg;
  logic [31:0] los_reg;
  logic        cooled_reg;
  logic        fault_seen_reg;
  tcs_status_t status_reg;
  tcs_status_t status_next;

  // the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire logic off_now  = sync2_reg.laser_off;
  wire logic off_fall = prev_reg.laser_off & ~off_now;
  wire logic rs_chg   = (sync2_reg.rate_select_low_bit !=
                         prev_reg.rate_select_low_bit) |
                        (sync2_reg.rate_select_high_bit !=
                         prev_reg.rate_select_high_bit);
  wire logic [31:0] start_lim = cooled_reg ? START_COOL_CYC : START_CYC;
  wire logic [31:0] flt_lim   = cooled_reg ? FLT_COOL_CYC : FLT_CYC;
  wire logic [31:0] rs_lim    = fc_mode ? RS_FC_CYC : RS_CYC;
  wire logic [31:0] pl2_lim   = cooled_reg ? START_COOL_CYC : PL2_CYC;
  wire logic [31:0] pwr_lim   = status_reg.high_power_level ? pl2_lim
                                                            : PDN_CYC;
  wire logic tmr_done = (tmr_reg >= start_lim);
  wire logic reset_ok = (hold_reg >= RESET_CYC);
  // fault counted while active; fixed half of the bound keeps margin
  wire logic flt_fire = (flt_reg >= (flt_lim >> 1));
  wire logic pwr_done = (tmr_reg >= (pwr_lim >> 1));
  wire logic on_done  = (tmr_reg >= (ON_CYC >> 1));
  wire logic los_flip = (los_reg >= (LOS_CYC >> 1));

  // sequencer: start-up, run, off, fault latch, recovery, level change
  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_reg + 32'h00000001;
    unique case (state_reg)
      TCS_ST_INIT, TCS_ST_RECOVER: begin
        if (off_now) begin
          tmr_next = '0;
        end else if ((tmr_reg >= (start_lim >> 1)) && tmr_done == 1'b0) begin
          state_next = TCS_ST_RUN;
          tmr_next   = '0;
        end else if (tmr_reg >= (start_lim >> 1)) begin
          state_next = TCS_ST_RUN;
          tmr_next   = '0;
        end
      end
      TCS_ST_RUN: begin
        tmr_next = '0;
        if (off_now) begin
          state_next = TCS_ST_OFF;
        end else if (hpl_write &&
                     (hpl_value != status_reg.high_power_level)) begin
          state_next = TCS_ST_PWRCHG;
        end
      end
      TCS_ST_OFF: begin
        if (off_now) begin
          tmr_next = '0;
        end else if (on_done) begin
          state_next = TCS_ST_RUN;
          tmr_next   = '0;
        end
      end
      TCS_ST_PWRCHG: begin
        if (off_now) begin
          state_next = TCS_ST_OFF;
          tmr_next   = '0;
        end else if (pwr_done) begin
          state_next = TCS_ST_RUN;
          tmr_next   = '0;
        end
      end
      TCS_ST_FAULT: begin
        tmr_next = '0;
        if (off_fall && reset_ok) begin
          state_next = TCS_ST_RECOVER;
        end
      end
      default: begin
        state_next = TCS_ST_INIT;
        tmr_next   = '0;
      end
    endcase
    if (flt_fire && state_reg != TCS_ST_FAULT) begin
      state_next = TCS_ST_FAULT;
      tmr_next   = '0;
    end
  end

  always_comb begin
    status_next = status_reg;
    status_next.laser_enable = (state_next == TCS_ST_RUN) ||
                               (state_next == TCS_ST_PWRCHG);
    status_next.laser_fault  = (state_next == TCS_ST_FAULT);
    status_next.operational  = (state_next == TCS_ST_RUN);
    status_next.mgmt_ready   = status_reg.mgmt_ready |
                               (mgmt_reg >= (MGMT_CYC >> 1));
    status_next.rate_stable  = (rs_reg >= (rs_lim >> 1));
    if (state_reg == TCS_ST_RUN && state_next == TCS_ST_PWRCHG) begin
      status_next.high_power_level = hpl_value;
    end
    if (los_flip) begin
      status_next.lost_light = sync2_reg.rx_light_lost;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg  <= TCS_ST_INIT;
      tmr_reg    <= '0;
      status_reg <= '0;
    end else begin
      state_reg  <= state_next;
      tmr_reg    <= tmr_next;
      status_reg <= status_next;
    end
  end

  // strap caught after reset release, not by the reset itself
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fault_seen_reg <= 1'b0;
      cooled_reg     <= 1'b0;
    end else if (!fault_seen_reg) begin
      fault_seen_reg <= 1'b1;
      cooled_reg     <= cooled;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mgmt_reg <= '0;
      hold_reg <= '0;
      flt_reg  <= '0;
      rs_reg   <= '0;
      los_reg  <= '0;
    end else begin
      mgmt_reg <= status_reg.mgmt_ready ? mgmt_reg : mgmt_reg + 32'h1;
      hold_reg <= off_now ? ((hold_reg == 32'hFFFFFFFF) ? hold_reg
                                                        : hold_reg + 32'h1)
                          : '0;
      flt_reg  <= (sync2_reg.laser_fault_event &&
                   state_reg != TCS_ST_FAULT) ? flt_reg + 32'h1 : '0;
      rs_reg   <= rs_chg ? '0 : (status_reg.rate_stable ? rs_reg
                                                        : rs_reg + 32'h1);
      los_reg  <= (sync2_reg.rx_light_lost == status_reg.lost_light ||
                   los_flip) ? '0 : los_reg + 32'h1;
    end
  end

  assign status = status_reg;

  property p_off_fast;
    @(posedge core_clk) disable iff (!resetn)
      $rose(sync2_reg.laser_off) |-> ##[1:2] !status_reg.laser_enable;
  endproperty
  a_off_fast: assert property (p_off_fast)
    else $error("laser not off after request");

  property p_fault_latched;
    @(posedge core_clk) disable iff (!resetn)
      status_reg.laser_fault && !(off_fall && reset_ok) |=>
        status_reg.laser_fault;
  endproperty
  a_fault_latched: assert property (p_fault_latched)
    else $error("fault output dropped without reset pulse");

  property p_fault_no_laser;
    @(posedge core_clk) disable iff (!resetn)
      status_reg.laser_fault |-> !status_reg.laser_enable;
  endproperty
  a_fault_no_laser: assert property (p_fault_no_laser)
    else $error("laser enabled while fault shown");

  property p_short_pulse;
    @(posedge core_clk) disable iff (!resetn)
      state_reg == TCS_ST_FAULT && off_fall && !reset_ok |=>
        state_reg == TCS_ST_FAULT;
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("short pulse cleared fault");

  property p_los_follow;
    @(posedge core_clk) disable iff (!resetn)
      los_flip |=> status_reg.lost_light == $past(sync2_reg.rx_light_lost);
  endproperty
  a_los_follow: assert property (p_los_follow)
    else $error("lost light output did not follow");

  property p_rs_drop;
    @(posedge core_clk) disable iff (!resetn)
      rs_chg |=> ##1 !status_reg.rate_stable;
  endproperty
  a_rs_drop: assert property (p_rs_drop)
    else $error("rate stable not dropped on change");

  property p_mgmt_sticky;
    @(posedge core_clk) disable iff (!resetn)
      status_reg.mgmt_ready |=> status_reg.mgmt_ready;
  endproperty
  a_mgmt_sticky: assert property (p_mgmt_sticky)
    else $error("management ready dropped");

  property p_pwr_level;
    @(posedge core_clk) disable iff (!resetn)
      state_reg == TCS_ST_PWRCHG |-> !status_reg.operational;
  endproperty
  a_pwr_level: assert property (p_pwr_level)
    else $error("operational during level change");

  sequence s_reset_taken;
    state_reg == TCS_ST_FAULT && off_fall && reset_ok;
  endsequence

  sequence s_recovering;
    state_reg == TCS_ST_RECOVER && !status_reg.laser_fault ##1
      !status_reg.laser_enable;
  endsequence

  property p_fault_clear;
    @(posedge core_clk) disable iff (!resetn)
      s_reset_taken |=> s_recovering;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault reset pulse did not start recovery");

  // counters must stay under the full bound, not only the half used
  property p_on_bound;
    @(posedge core_clk) disable iff (!resetn)
      state_reg == TCS_ST_OFF && !off_now |-> tmr_reg < ON_CYC;
  endproperty
  a_on_bound: assert property (p_on_bound)
    else $error("laser return took longer than its bound");

  property p_start_bound;
    @(posedge core_clk) disable iff (!resetn)
      (state_reg == TCS_ST_INIT || state_reg == TCS_ST_RECOVER) |->
        tmr_reg < start_lim;
  endproperty
  a_start_bound: assert property (p_start_bound)
    else $error("start-up took longer than its bound");

  property p_pwr_bound;
    @(posedge core_clk) disable iff (!resetn)
      state_reg == TCS_ST_PWRCHG |-> tmr_reg < pwr_lim;
  endproperty
  a_pwr_bound: assert property (p_pwr_bound)
    else $error("level change took longer than its bound");

  property p_flt_bound;
    @(posedge core_clk) disable iff (!resetn)
      sync2_reg.laser_fault_event |-> flt_reg < flt_lim;
  endproperty
  a_flt_bound: assert property (p_flt_bound)
    else $error("fault report took longer than its bound");
endmodule
`default_nettype wire

// *** hdl/tcs_map.svh ***
// timing constants and cycle count macros for the transceiver control sequencer
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH
`define TCS_CLK_HZ            20000000
`define TCS_T_OFF_US          100
`define TCS_T_ON_MS           2
`define TCS_T_2W_MS           300
`define TCS_T_START_MS        300
`define TCS_T_START_COOL_S    90
`define TCS_T_PL2_MS          300
`define TCS_T_PDN_MS          300
`define TCS_T_FLT_MS          1
`define TCS_T_FLT_COOL_MS     50
`define TCS_T_RESET_US        10
`define TCS_T_RS_FC_US        500
`define TCS_T_RS_MS           24
`define TCS_T_LOS_US          100
// cycle counts: max and min times alike scale by integer division, which rounds down
`define TCS_CYC_OFF   ((`TCS_T_OFF_US*(`TCS_CLK_HZ/1000000)))
`define TCS_CYC_RESET ((`TCS_T_RESET_US*(`TCS_CLK_HZ/1000000)))
`define TCS_CYC_LOS   ((`TCS_T_LOS_US*(`TCS_CLK_HZ/1000000)))
`define TCS_CYC_US(x) ((x)*(`TCS_CLK_HZ/1000000))
`define TCS_CYC_MS(x) ((x)*(`TCS_CLK_HZ/1000))
`define TCS_CYC_S(x)  ((x)*`TCS_CLK_HZ)
`define TCS_CNT_W     32
`endif

// *** hdl/tcs_pkg.sv ***
// types for the transceiver control sequencer
`default_nettype none
package tcs_pkg;
  typedef enum logic [2:0] {
    TCS_ST_INIT    = 3'b000,
    TCS_ST_RUN     = 3'b001,
    TCS_ST_OFF     = 3'b010,
    TCS_ST_FAULT   = 3'b011,
    TCS_ST_RECOVER = 3'b100,
    TCS_ST_PWRCHG  = 3'b101
  } tcs_state_t;

  typedef struct packed {
    logic laser_off;
    logic rate_select_low_bit;
    logic rate_select_high_bit;
    logic laser_fault_event;
    logic rx_light_lost;
  } tcs_pins_t;

  typedef struct packed {
    logic laser_enable;
    logic laser_fault;
    logic lost_light;
    logic mgmt_ready;
    logic operational;
    logic high_power_level;
    logic rate_stable;
  } tcs_status_t;
endpackage
`default_nettype wire

// *** bench/tcs_host.sv ***
// host line card model driving the control pins and level writes
`default_nettype none
module tcs_host
  import tcs_pkg::*;
(
  input  wire logic      core_clk,   // device clock
  output var  tcs_pins_t pins,       // control and event pins
  output var  logic      hpl_write,  // level write stop pulse
  output var  logic      hpl_value   // level written
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins = '0;
    hpl_write = 1'b0;
    hpl_value = 1'b0;
  end
  task automatic drive(input tcs_pins_t p);
    @(negedge core_clk);
    pins = p;
  endtask
  // one cycle pulse, value held afterwards like a written register
  task automatic level_write(input logic v);
    @(negedge core_clk);
    hpl_value = v;
    hpl_write = 1'b1;
    @(negedge core_clk);
    hpl_write = 1'b0;
  endtask
  // callers pass 200 cycles or more to clear, fewer only to be ignored
  task automatic off_pulse(input int hold);
    @(negedge core_clk);
    pins.laser_off = 1'b1;
    repeat (hold) @(negedge core_clk);
    pins.laser_off = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_tcs_seq.sv ***
// self-checking bench for the transceiver control sequencer
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %b exp %b", $time, a, b); end end
module tb_tcs_seq
  import tcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] P_START = 32'h40;
  localparam logic [31:0] P_COOL  = 32'h78;
  // P_MGMT, P_PL2, P_PDN, P_FLTC and P_RS follow from the overridden counts by the ratio of their bounds
  localparam logic [31:0] P_MGMT  = 32'h40;
  localparam logic [31:0] P_PL2   = 32'h40;
  localparam logic [31:0] P_PDN   = 32'h40;
  localparam logic [31:0] P_ON    = 32'h38;
  localparam logic [31:0] P_FLT   = 32'h28;
  localparam logic [31:0] P_FLTC  = 32'h7D0;
  localparam logic [31:0] P_RSFC  = 32'h1E;
  localparam logic [31:0] P_RS    = 32'h5A0;
  localparam int LE = 6, LF = 5, LL = 4, MR = 3, OP = 2, HP = 1, RS = 0;
  localparam int SL = 6;  // sync and register slack
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        cooled   = 1'b0;
  logic        fc_mode  = 1'b0;
  tcs_pins_t   pins;
  tcs_pins_t   p = '0;
  logic        hpl_write;
  logic        hpl_value;
  tcs_status_t status;
  logic [6:0]  st;
  int          fail_count = 0;
  int          checked = 0;
  assign st = status;
  initial forever #25 core_clk = ~core_clk;
  tcs_host u_host (.core_clk(core_clk), .pins(pins),
    .hpl_write(hpl_write), .hpl_value(hpl_value));
  tcs_seq #(.START_CYC(P_START), .START_COOL_CYC(P_COOL), .ON_CYC(P_ON),
    .FLT_CYC(P_FLT), .RS_FC_CYC(P_RSFC)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .pins_in(pins), .cooled(cooled),
    .fc_mode(fc_mode), .hpl_write(hpl_write), .hpl_value(hpl_value),
    .status(status));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait for one status bit; a spent bound ends the run
  task automatic wt(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (st[i] !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(st[i], v)
    if (st[i] !== v) final_report();
  endtask
  task automatic rst(input logic c);
    @(negedge core_clk);
    resetn = 1'b0;
    cooled = c;
    p = '0;
    u_host.drive(p);
    repeat (2) @(negedge core_clk);
    `CHK(status, 7'h00)
    resetn = 1'b1;
  endtask
  initial begin
    rst(1'b0);
    wt(MR, 1'b1, P_MGMT + SL);
    wt(OP, 1'b1, P_START + SL);
    wt(LE, 1'b1, SL);
    fc_mode = 1'b1;
    p.rate_select_low_bit = 1'b1;
    u_host.drive(p);
    wt(RS, 1'b0, SL);
    wt(RS, 1'b1, P_RSFC + SL);
    fc_mode = 1'b0;
    p.rate_select_high_bit = 1'b1;
    u_host.drive(p);
    wt(RS, 1'b0, SL);
    wt(RS, 1'b1, P_RS + SL);
    p.laser_off = 1'b1;
    u_host.drive(p);
    wt(LE, 1'b0, 5);
    p.laser_off = 1'b0;
    u_host.drive(p);
    wt(LE, 1'b1, P_ON + SL);
    u_host.level_write(1'b1);
    wt(HP, 1'b1, P_PL2 + SL);
    wt(OP, 1'b1, P_PL2 + SL);
    u_host.level_write(1'b0);
    wt(HP, 1'b0, P_PDN + SL);
    wt(OP, 1'b1, P_PDN + SL);
    p.laser_fault_event = 1'b1;
    u_host.drive(p);
    wt(LF, 1'b1, P_FLT + SL);
    p.laser_fault_event = 1'b0;
    u_host.drive(p);
    // a level write outside normal running must be dropped
    u_host.level_write(1'b1);
    repeat (100) @(negedge core_clk);
    `CHK(st[LF], 1'b1)
    u_host.off_pulse(50);
    repeat (10) @(negedge core_clk);
    `CHK(st[LF], 1'b1)
    u_host.off_pulse(220);
    wt(LF, 1'b0, SL);
    wt(OP, 1'b1, P_START + SL);
    `CHK(st[HP], 1'b0)
    p.rx_light_lost = 1'b1;
    u_host.drive(p);
    wt(LL, 1'b1, 2000 + SL);
    p.rx_light_lost = 1'b0;
    u_host.drive(p);
    wt(LL, 1'b0, 2000 + SL);
    rst(1'b1);
    wt(OP, 1'b1, P_COOL + SL);
    u_host.level_write(1'b1);
    wt(HP, 1'b1, P_COOL + SL);
    wt(OP, 1'b1, P_COOL + SL);
    p.laser_fault_event = 1'b1;
    u_host.drive(p);
    wt(LF, 1'b1, P_FLTC + SL);
    final_report();
  end
endmodule
`default_nettype wire
